/* File: atd_params.svh */
// Offsets, field positions, reset values and timing counts of the trigger and delay control
`ifndef ATD_PARAMS_SVH
`define ATD_PARAMS_SVH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define ATD_OFF_CTRL       8'h00
`define ATD_OFF_START      8'h04
`define ATD_OFF_STATUS     8'h08
`define ATD_OFF_INJ_SEQ    8'h0c
`define ATD_OFF_REG_SEQ1   8'h10
`define ATD_OFF_RESULT     8'h24
`define ATD_REG_SEQ_COUNT  5
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ATD_CTRL_REG_EDGE  0
`define ATD_CTRL_INJ_EDGE  2
`define ATD_CTRL_REG_SRC   4
`define ATD_CTRL_INJ_SRC   8
`define ATD_CTRL_DEPTH     12
`define ATD_CTRL_DELS      14
`define ATD_CTRL_PER_CONVERSION_FLAG_SELECT      17
`define ATD_CTRL_AUTO      18
`define ATD_START_REG      0
`define ATD_START_INJ      1
`define ATD_STAT_EOC       0
`define ATD_STAT_JDONE     1
`define ATD_STAT_RNR       2
`define ATD_STAT_JNR       3
`define ATD_STAT_RBUSY     4
`define ATD_STAT_JBUSY     5
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ATD_RST_CTRL       32'h0000_0000
`define ATD_RST_SEQ        32'h0000_0000
// ----------------------------------------------------------------
// Timing counts in clock cycles
// ----------------------------------------------------------------
`define ATD_SAMPLE_CYC     5'h04
`define ATD_CONV_12B       5'h0c
`define ATD_CONV_10B       5'h0b
`define ATD_CONV_8B        5'h09
`define ATD_CONV_6B        5'h07
`define ATD_MUTE_CYC       2'h2
`define ATD_ABORT_CONV_CYC 4'h5
`define ATD_ABORT_BUS_CYC  4'h5
`define ATD_EOC_SYNC_CYC   12'h001
`define ATD_END_SYNC_CYC   12'h003
`define ATD_DLY_BASE       4
`endif

/* File: atd_pkg.sv */
// Types shared by the trigger and delay control
package atd_pkg;
	typedef enum logic [1:0] {phase_idle, phase_reg, phase_inj} atd_phase_type;
	typedef struct packed {
		logic               ap_valid;
		logic               ap_write;
		logic [7:0]         ap_addr;
		logic [31:0]        hrdata;
		logic [1:0]         reg_edge;
		logic [1:0]         inj_edge;
		logic [3:0]         reg_src;
		logic [3:0]         inj_src;
		logic [1:0]         depth;
		logic [2:0]         dels;
		logic               per_conversion_flag_select;
		logic               auto_inj;
		logic [31:0]        inj_seq;
		logic [4:0][31:0]   reg_seq;
		logic [1:0]         reg_sync;
		logic [1:0]         inj_sync;
		logic               reg_prev;
		logic               inj_prev;
		logic [1:0]         reg_mute;
		logic [1:0]         inj_mute;
		atd_phase_type      st;
		logic [4:0]         conv_cnt;
		logic [4:0]         reg_idx;
		logic [1:0]         inj_idx;
		logic               reg_pend;
		logic               inj_pend;
		logic [11:0]        reg_dly;
		logic [11:0]        inj_dly;
		logic               reg_hold;
		logic               inj_hold;
		logic [3:0]         reg_nr;
		logic [3:0]         inj_nr;
		logic               eoc;
		logic               jdone;
		logic [15:0]        result;
	} atd_state_type;
endpackage

/* File: atd_trigger_ctrl.sv */
// Trigger selection, abort, resolution timing, freeze and delay insertion for a SAR converter
// Notes on behaviour
// - Edge field: off, rising, falling, both
// - Edge field changes take effect on fly
// - Four-bit source selector per group
// - Regular: timers 0-10, reserved, pin 15
// - Injected: own timers, reserved, own pin
// - Injected trigger interrupts running regular conversion
// - Source change mutes detection two cycles
// - Injected sequence write aborts, clears pending
// - Abort recovery time; poll not-ready flag
// - Regular sequence write aborts, clears pending
// - Resolution sets conversion length after sample
// - Delay after conversions; same-group triggers ignored
// - No cross-group delay; injected starts immediately
// - Resumed regular waits only own delay
// - Auto mode: regular waits injected delay
// - Auto mode: late regular trigger held pending
// - Freeze: wait for result read/flag clear
// - Delay mode: wait configured cycles per group
// - Flag select moves regular delay to sequence end
// - Gap adds conversion and delay sync cycles
// - Flag select: done flag per conversion/sequence
// - Auto mode converts injected after regular
//
// Decided for this implementation: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ns
`include "atd_params.svh"
module atd_trigger_ctrl #(
	parameter int DLY_BASE = `ATD_DLY_BASE
) (
	// Clock and reset
	input  wire logic         hclk,
	input  wire logic         hresetn,
	// AHB-Lite slave
	input  wire logic         hsel,
	input  wire logic [31:0]  haddr,
	input  wire logic [1:0]   htrans,
	input  wire logic         hwrite,
	input  wire logic [2:0]   hsize,
	input  wire logic [31:0]  hwdata,
	input  wire logic         hready,
	output logic              hreadyout,
	output logic              hresp,
	output logic [31:0]       hrdata,
	// Trigger sources
	input  wire logic [10:0]  reg_timer_events,
	input  wire logic         reg_pin_line,
	input  wire logic [10:0]  inj_timer_events,
	input  wire logic         inj_pin_line,
	// Converter activity
	output logic              regular_busy,
	output logic              injected_busy
);
	import atd_pkg::*;

	// ----------------------------------------------------------------
	// Parameter check and helpers
	// ----------------------------------------------------------------
	// Longest delay is DLY_BASE << 6 plus sync cycles; it must fit 12 bits
	// Checked while elaborating, so a bad value never reaches a netlist
	if (DLY_BASE < 1 || DLY_BASE > 63) begin : g_bad_dly_base
		$error("DLY_BASE out of range 1..63");
	end

	// Sum of both recovery spans, so a polling driver never restarts early
	localparam logic [3:0] ABORT_CYC = `ATD_ABORT_CONV_CYC + `ATD_ABORT_BUS_CYC;

	// Edge decode shared by both groups
	function automatic logic edge_hit(input logic [1:0] mode, input logic cur, input logic prev);
		unique case (mode)
			2'h0: edge_hit = 1'b0;
			2'h1: edge_hit = cur & ~prev;
			2'h2: edge_hit = ~cur & prev;
			2'h3: edge_hit = cur ^ prev;
		endcase
	endfunction

	// Reserved codes select nothing so they can never fire
	// The pin line always sits behind the top code of each group
	function automatic logic src_pick(input logic [3:0] sel, input logic [10:0] ev, input logic pin);
		if (sel <= 4'ha) begin
			src_pick = ev[sel];
		end else if (sel == 4'hf) begin
			src_pick = pin;
		end else begin
			src_pick = 1'b0;
		end
	endfunction

	// Sample time plus resolution-dependent conversion cycles
	function automatic logic [4:0] conv_len(input logic [1:0] depth);
		unique case (depth)
			2'h0: conv_len = `ATD_SAMPLE_CYC + `ATD_CONV_12B;
			2'h1: conv_len = `ATD_SAMPLE_CYC + `ATD_CONV_10B;
			2'h2: conv_len = `ATD_SAMPLE_CYC + `ATD_CONV_8B;
			2'h3: conv_len = `ATD_SAMPLE_CYC + `ATD_CONV_6B;
		endcase
	endfunction

	// Delay length grows by powers of two with the selector code
	function automatic logic [11:0] dly_len(input logic [2:0] dels);
		dly_len = (12'(DLY_BASE) << (dels - 3'h1)) + `ATD_EOC_SYNC_CYC + `ATD_END_SYNC_CYC;
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	atd_state_type s;
	atd_state_type n;
	logic          ap;
	logic          wr;
	logic          soft_r;
	logic          soft_j;
	logic          reg_hw;
	logic          inj_hw;
	logic          reg_go;
	logic          inj_go;
	logic          eoc_set;
	logic          eoc_clr;
	logic          jdone_set;
	logic          jdone_clr;
	logic          rhold_set;
	logic          jhold_set;
	logic          reg_last;
	logic          inj_last;
	logic          reg_abort;
	logic          inj_abort;

	// Slave never stretches; every transfer answers OKAY
	assign hreadyout     = 1'b1;
	assign hresp         = 1'b0;
	assign hrdata        = s.hrdata;
	assign regular_busy  = (s.st == phase_reg);
	assign injected_busy = (s.st == phase_inj);

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		n         = s;
		eoc_set   = 1'b0;
		jdone_set = 1'b0;
		rhold_set = 1'b0;
		jhold_set = 1'b0;
		reg_abort = 1'b0;
		inj_abort = 1'b0;

		// Bus address phase captured; writes land in the data phase
		ap         = hsel && hready && htrans[1];
		n.ap_valid = ap;
		n.ap_write = hwrite;
		n.ap_addr  = haddr[7:0];
		wr         = s.ap_valid && s.ap_write;
		soft_r     = wr && s.ap_addr == `ATD_OFF_START && hwdata[`ATD_START_REG];
		soft_j     = wr && s.ap_addr == `ATD_OFF_START && hwdata[`ATD_START_INJ];
		jdone_clr  = wr && s.ap_addr == `ATD_OFF_STATUS && hwdata[`ATD_STAT_JDONE];
		// Reading the result clears the end flag just like writing its clear bit
		eoc_clr    = (wr && s.ap_addr == `ATD_OFF_STATUS && hwdata[`ATD_STAT_EOC]) ||
		             (ap && !hwrite && haddr[7:0] == `ATD_OFF_RESULT);

		// Read data registered at the address phase, zero when unmapped
		if (ap && !hwrite) begin
			n.hrdata = 32'h0000_0000;
			unique case (haddr[7:0])
				`ATD_OFF_CTRL:    n.hrdata = {13'h0000, s.auto_inj, s.per_conversion_flag_select, s.dels, s.depth,
				                              s.inj_src, s.reg_src, s.inj_edge, s.reg_edge};
				`ATD_OFF_STATUS:  n.hrdata = {26'h000_0000, s.st == phase_inj, s.st == phase_reg,
				                              s.inj_nr != 4'h0, s.reg_nr != 4'h0, s.jdone, s.eoc};
				`ATD_OFF_INJ_SEQ: n.hrdata = s.inj_seq;
				`ATD_OFF_RESULT:  n.hrdata = {16'h0000, s.result};
				default: begin
					for (int i = 0; i < `ATD_REG_SEQ_COUNT; i++) begin
						if (haddr[7:0] == 8'(`ATD_OFF_REG_SEQ1 + 4 * i)) begin
							n.hrdata = s.reg_seq[i];
						end
					end
				end
			endcase
		end

		// Two-flop synchronisers; only the second stage feeds the edge detect
		n.reg_sync = {s.reg_sync[0], src_pick(s.reg_src, reg_timer_events, reg_pin_line)};
		n.inj_sync = {s.inj_sync[0], src_pick(s.inj_src, inj_timer_events, inj_pin_line)};
		n.reg_prev = s.reg_sync[1];
		n.inj_prev = s.inj_sync[1];
		reg_hw     = s.reg_mute == 2'h0 && edge_hit(s.reg_edge, s.reg_sync[1], s.reg_prev);
		inj_hw     = s.inj_mute == 2'h0 && edge_hit(s.inj_edge, s.inj_sync[1], s.inj_prev);

		// Down counters that stop at zero
		if (s.reg_mute != 2'h0) n.reg_mute = s.reg_mute - 2'h1;
		if (s.inj_mute != 2'h0) n.inj_mute = s.inj_mute - 2'h1;
		if (s.reg_dly != 12'h000) n.reg_dly = s.reg_dly - 12'h001;
		if (s.inj_dly != 12'h000) n.inj_dly = s.inj_dly - 12'h001;
		if (s.reg_nr != 4'h0) n.reg_nr = s.reg_nr - 4'h1;
		if (s.inj_nr != 4'h0) n.inj_nr = s.inj_nr - 4'h1;

		// Start conditions; injected never waits for the regular delay
		inj_go   = s.inj_pend && s.inj_dly == 12'h000 && !s.inj_hold && s.inj_nr == 4'h0;
		reg_go   = s.reg_pend && s.reg_dly == 12'h000 && !s.reg_hold && s.reg_nr == 4'h0 &&
		           !(s.auto_inj && (s.inj_dly != 12'h000 || s.inj_hold));
		reg_last = s.reg_idx == s.reg_seq[0][4:0];
		inj_last = s.inj_idx == s.inj_seq[1:0];

		// Sequencer
		unique case (s.st)
			phase_idle: begin
				if (inj_go) begin
					n.st       = phase_inj;
					n.inj_pend = 1'b0;
					n.inj_idx  = 2'h0;
					n.conv_cnt = conv_len(s.depth) - 5'h01;
				end else if (reg_go) begin
					n.st       = phase_reg;
					n.reg_pend = 1'b0;
					n.conv_cnt = conv_len(s.depth) - 5'h01;
				end
			end
			phase_reg: begin
				if (inj_go && !s.auto_inj) begin
					// Interrupted conversion is redone from the same position
					n.st       = phase_inj;
					n.reg_pend = 1'b1;
					n.inj_pend = 1'b0;
					n.inj_idx  = 2'h0;
					n.conv_cnt = conv_len(s.depth) - 5'h01;
				end else if (s.conv_cnt != 5'h00) begin
					n.conv_cnt = s.conv_cnt - 5'h01;
				end else begin
					n.st       = phase_idle;
					n.result   = s.result + 16'h0001;
					n.reg_idx  = reg_last ? 5'h00 : s.reg_idx + 5'h01;
					n.reg_pend = !reg_last;
					eoc_set    = s.per_conversion_flag_select || reg_last;
					rhold_set  = s.dels == 3'h1;
					if (s.dels > 3'h1 && (!s.per_conversion_flag_select || reg_last)) begin
						n.reg_dly = dly_len(s.dels);
					end
					if (reg_last && s.auto_inj) begin
						n.inj_pend = 1'b1;
					end
				end
			end
			phase_inj: begin
				if (s.conv_cnt != 5'h00) begin
					n.conv_cnt = s.conv_cnt - 5'h01;
				end else if (!inj_last) begin
					n.inj_idx  = s.inj_idx + 2'h1;
					n.conv_cnt = conv_len(s.depth) - 5'h01;
				end else begin
					n.st      = phase_idle;
					jdone_set = 1'b1;
					jhold_set = s.dels == 3'h1;
					if (s.dels > 3'h1) begin
						n.inj_dly = dly_len(s.dels);
					end
				end
			end
		endcase

		// Triggers in their own group's delay are dropped, later ones held
		if ((reg_hw || soft_r) && s.reg_dly == 12'h000) begin
			n.reg_pend = 1'b1;
		end
		if (((inj_hw && !s.auto_inj) || soft_j) && s.inj_dly == 12'h000) begin
			n.inj_pend = 1'b1;
		end

		// Control writes; edge fields apply at once, source change mutes
		if (wr && s.ap_addr == `ATD_OFF_CTRL) begin
			n.reg_edge = hwdata[`ATD_CTRL_REG_EDGE +: 2];
			n.inj_edge = hwdata[`ATD_CTRL_INJ_EDGE +: 2];
			n.reg_src  = hwdata[`ATD_CTRL_REG_SRC +: 4];
			n.inj_src  = hwdata[`ATD_CTRL_INJ_SRC +: 4];
			n.depth    = hwdata[`ATD_CTRL_DEPTH +: 2];
			n.dels     = hwdata[`ATD_CTRL_DELS +: 3];
			n.per_conversion_flag_select     = hwdata[`ATD_CTRL_PER_CONVERSION_FLAG_SELECT];
			n.auto_inj = hwdata[`ATD_CTRL_AUTO];
			if (hwdata[`ATD_CTRL_REG_SRC +: 4] != s.reg_src) n.reg_mute = `ATD_MUTE_CYC;
			if (hwdata[`ATD_CTRL_INJ_SRC +: 4] != s.inj_src) n.inj_mute = `ATD_MUTE_CYC;
		end

		// Sequence writes abort their group, overriding its pending and index fields above; same-cycle starts run except an injected preemption on a regular write
		if (wr && s.ap_addr == `ATD_OFF_INJ_SEQ) begin
			inj_abort = 1'b1;
			n.inj_seq = hwdata;
		end
		for (int i = 0; i < `ATD_REG_SEQ_COUNT; i++) begin
			if (wr && s.ap_addr == 8'(`ATD_OFF_REG_SEQ1 + 4 * i)) begin
				reg_abort    = 1'b1;
				n.reg_seq[i] = hwdata;
			end
		end
		if (inj_abort) begin
			if (s.st == phase_inj) n.st = phase_idle;
			n.inj_pend = 1'b0;
			n.inj_idx  = 2'h0;
			n.inj_nr   = ABORT_CYC;
		end
		if (reg_abort) begin
			if (s.st == phase_reg) n.st = phase_idle;
			n.reg_pend = 1'b0;
			n.reg_idx  = 5'h00;
			n.reg_nr   = ABORT_CYC;
		end

		// Sticky flags; a set in the same cycle as a clear wins
		// A freeze hold outlives a mode change; reading the result releases the regular one, the injected one needs its flag clear
		n.eoc      = (s.eoc & ~eoc_clr) | eoc_set;
		n.jdone    = (s.jdone & ~jdone_clr) | jdone_set;
		n.reg_hold = (s.reg_hold & ~eoc_clr) | rhold_set;
		n.inj_hold = (s.inj_hold & ~jdone_clr) | jhold_set;
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s          <= '0;
			s.st       <= phase_idle;
			s.inj_seq  <= `ATD_RST_SEQ;
			s.reg_seq  <= {`ATD_REG_SEQ_COUNT{`ATD_RST_SEQ}};
			s.reg_edge <= 2'(`ATD_RST_CTRL >> `ATD_CTRL_REG_EDGE);
		end else begin
			s <= n;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	sequence seq_src_change;
		wr && s.ap_addr == `ATD_OFF_CTRL && hwdata[`ATD_CTRL_REG_SRC +: 4] != s.reg_src;
	endsequence
	sequence seq_inj_abort_busy;
		s.st == phase_inj && inj_abort;
	endsequence

	AST_MUTE_TWO: assert property (seq_src_change |=> !reg_hw ##1 !reg_hw)
		else $error("trigger seen during source switchover");
	AST_INJ_ABORT: assert property (seq_inj_abort_busy |=> s.st != phase_inj && !s.inj_pend)
		else $error("injected abort did not stop conversion");
	// Ten not-ready cycles from the abort (eight plus two), then clear
	AST_JNR_HOLD: assert property ($rose(s.inj_nr != 4'h0) |-> (s.inj_nr != 4'h0)[*8] ##1 (s.inj_nr != 4'h0)[*2]
		##1 (s.inj_nr == 4'h0 || inj_abort))
		else $error("injected not-ready flag wrong length");
	AST_REG_ABORT: assert property (s.st == phase_reg && reg_abort |=> s.st == phase_idle && s.reg_idx == 5'h00)
		else $error("regular abort did not stop conversion");
	AST_PREEMPT: assert property (s.st == phase_reg && inj_go && !s.auto_inj && !reg_abort && !inj_abort
		|=> s.st == phase_inj && s.reg_pend)
		else $error("injected trigger did not interrupt regular");
	AST_COUNT_DOWN: assert property (s.st != phase_idle && s.conv_cnt != 5'h00 && !reg_abort && !inj_abort && !inj_go
		|=> s.conv_cnt == $past(s.conv_cnt) - 5'h01)
		else $error("conversion counter did not step");
	AST_DLY_IGNORE: assert property (s.reg_dly > 12'h001 && !s.reg_pend && s.st == phase_idle && !reg_abort
		|=> !s.reg_pend)
		else $error("regular trigger accepted during delay");
	AST_FREEZE: assert property (s.st == phase_idle && s.reg_hold && !inj_go |=> s.st != phase_reg)
		else $error("regular start while frozen");
	AST_SET_WINS: assert property (eoc_set && eoc_clr |=> s.eoc)
		else $error("end flag lost when set and cleared together");
	AST_AUTO_WAIT: assert property (s.auto_inj && s.inj_dly != 12'h000 && s.st == phase_idle && !inj_go
		|=> s.st != phase_reg)
		else $error("regular started inside injected delay");
endmodule

/* File: atd_event_source.sv */
// Timer event and pin line model that feeds the converter control trigger inputs
`timescale 1ns/1ns
module atd_event_source #(
	parameter int MIN_GAP = 40
) (
	// Clock
	input  wire logic        hclk,
	// Event lines toward the converter control
	output logic [10:0]      reg_timer_events,
	output logic             reg_pin_line,
	output logic [10:0]      inj_timer_events,
	output logic             inj_pin_line
);
	int gap;

	// Lines idle low from time zero
	initial begin
		reg_timer_events = 11'h000;
		reg_pin_line = 1'b0;
		inj_timer_events = 11'h000;
		inj_pin_line = 1'b0;
		gap = MIN_GAP;
	end

	// Cycles since the last event, so a new one never lands inside a running sequence
	always @(posedge hclk) begin
		if (gap < MIN_GAP) gap <= gap + 1;
	end

	// Drive one line of a group; a reserved code moves every line of the group at once
	task automatic set_line(input int g, input int code, input logic v);
		while (gap < MIN_GAP) @(posedge hclk);
		gap = 0;
		if (g == 0 && code < 11) reg_timer_events[code] <= v;
		if (g == 1 && code < 11) inj_timer_events[code] <= v;
		if (g == 0 && code >= 11) reg_pin_line <= v;
		if (g == 1 && code >= 11) inj_pin_line <= v;
		if (g == 0 && code > 10 && code < 15) reg_timer_events <= {11{v}};
		if (g == 1 && code > 10 && code < 15) inj_timer_events <= {11{v}};
	endtask
endmodule

/* File: adc_trigger_abort_delay_control_bench.sv */
// Self-checking bench for the trigger, abort and delay control
`timescale 1ns/1ns
`include "atd_params.svh"
module adc_trigger_abort_delay_control_bench;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, regular_busy, injected_busy;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [10:0] reg_ev, inj_ev;
	logic        reg_pin, inj_pin;
	logic [15:0] lfsr_q;
	int          failures, n_checks, exp_done, cnt, code, ed, er, ef, k;
	int          conv_len[4] = '{16, 15, 13, 11};

	always #4 hclk = ~hclk;

	atd_trigger_ctrl #(.DLY_BASE(1)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .reg_timer_events(reg_ev),
		.reg_pin_line(reg_pin), .inj_timer_events(inj_ev), .inj_pin_line(inj_pin),
		.regular_busy(regular_busy), .injected_busy(injected_busy));

	atd_event_source i_src (.hclk(hclk), .reg_timer_events(reg_ev), .reg_pin_line(reg_pin),
		.inj_timer_events(inj_ev), .inj_pin_line(inj_pin));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask

	// One single word transfer; entered right after a rising edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h000000, a};
		hwrite <= w;
		hsize <= 3'b010;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	// Count conversion starts of a group; sampled on falling edges where busy has settled
	task automatic watch(input int g, input int n);
		logic prev;
		prev = g ? injected_busy : regular_busy;
		cnt = 0;
		repeat (n) begin
			@(negedge hclk);
			if ((g ? injected_busy : regular_busy) === 1'b1 && prev !== 1'b1) cnt++;
			prev = g ? injected_busy : regular_busy;
		end
		@(posedge hclk);
	endtask

	// Wait for a conversion of a group and measure how many cycles busy stands
	task automatic span(input int g);
		k = 0;
		cnt = 0;
		while ((g ? injected_busy : regular_busy) !== 1'b1 && k < 30) begin
			@(negedge hclk);
			k++;
		end
		while ((g ? injected_busy : regular_busy) === 1'b1) begin
			@(negedge hclk);
			cnt++;
		end
		@(posedge hclk);
	endtask

	task automatic final_report;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	// A hang counts as a mismatch; the whole run needs under two thousand cycles
	initial begin
		#400000;
		failures++;
		final_report;
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		hclk = 1'b0;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0;
		failures = 0;
		n_checks = 0;
		exp_done = 0;
		lfsr_q = 16'h01f8;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		// Every mapped word reads zero after reset; an unmapped word keeps nothing
		for (int a = 0; a <= 'h24; a += 4) begin
			bus(1'b0, 8'(a), 32'h0);
			chk("reset_value", 32'h0, rd);
		end
		lfsr_q = lfsr_next(lfsr_q);
		bus(1'b1, 8'h30, {lfsr_q, lfsr_q});
		bus(1'b0, 8'h30, 32'h0);
		chk("unmapped", 32'h0, rd);
		chk("resp_okay", 32'h0, 32'(hresp));
		// Conversion length for every bit depth
		for (int d = 0; d < 4; d++) begin
			bus(1'b1, `ATD_OFF_CTRL, 32'(d) << `ATD_CTRL_DEPTH);
			bus(1'b1, `ATD_OFF_START, 32'h1);
			span(0);
			chk("conv_len", 32'(conv_len[d]), 32'(cnt));
			exp_done++;
		end
		bus(1'b0, `ATD_OFF_STATUS, 32'h0);
		chk("eoc_set", 32'h1, 32'(rd[`ATD_STAT_EOC]));
		bus(1'b0, `ATD_OFF_RESULT, 32'h0);
		chk("result", 32'(exp_done), {16'h0, rd[15:0]});
		bus(1'b0, `ATD_OFF_STATUS, 32'h0);
		chk("eoc_cleared", 32'h0, 32'(rd[`ATD_STAT_EOC]));
		// Edge modes on random timer codes, the pin code and a reserved code, both groups
		for (int g = 0; g < 2; g++) begin
			for (int e = 0; e < 6; e++) begin
				lfsr_q = lfsr_next(lfsr_q);
				code = (e < 4) ? lfsr_q % 11 : (e == 4) ? 15 : 11 + lfsr_q % 4;
				ed = (e < 4) ? e : 3;
				er = (e < 4) ? ed & 1 : (e == 4);
				ef = (e < 4) ? ed >> 1 : (e == 4);
				bus(1'b1, `ATD_OFF_CTRL, g ? 32'(ed << 2 | code << 8) : 32'(ed | code << 4));
				repeat (4) @(posedge hclk);
				i_src.set_line(g, code, 1'b1);
				watch(g, 30);
				chk("rise_trigger", 32'(er), 32'(cnt));
				i_src.set_line(g, code, 1'b0);
				watch(g, 30);
				chk("fall_trigger", 32'(ef), 32'(cnt));
				if (g == 0) exp_done += er + ef;
			end
		end
		bus(1'b1, `ATD_OFF_CTRL, 32'h0);
		// Injected start in mid regular conversion; regular restarts afterwards
		bus(1'b1, `ATD_OFF_START, 32'h1);
		repeat (6) @(posedge hclk);
		bus(1'b1, `ATD_OFF_START, 32'h2);
		watch(1, 6);
		chk("preempt_start", 32'h1, 32'(cnt));
		@(negedge hclk);
		chk("regular_paused", 32'h0, 32'(regular_busy));
		@(posedge hclk);
		span(1);
		span(0);
		chk("resumed_len", 32'd16, 32'(cnt));
		exp_done++;
		// Sequence writes abort and hold the not-ready flag until recovery
		for (int g = 0; g < 2; g++) begin
			bus(1'b1, `ATD_OFF_START, g ? 32'h2 : 32'h1);
			repeat (5) @(posedge hclk);
			// A second start while busy leaves a pending trigger for the abort to drop
			bus(1'b1, `ATD_OFF_START, g ? 32'h2 : 32'h1);
			bus(1'b1, g ? `ATD_OFF_INJ_SEQ : `ATD_OFF_REG_SEQ1, 32'h0);
			repeat (2) @(negedge hclk);
			chk("aborted", 32'h0, 32'(g ? injected_busy : regular_busy));
			@(posedge hclk);
			bus(1'b0, `ATD_OFF_STATUS, 32'h0);
			chk("not_ready", 32'h1, 32'(rd[g ? `ATD_STAT_JNR : `ATD_STAT_RNR]));
			k = 0;
			do begin
				bus(1'b0, `ATD_OFF_STATUS, 32'h0);
				k++;
			end while (rd[g ? `ATD_STAT_JNR : `ATD_STAT_RNR] !== 1'b0 && k < 20);
			chk("recovered", 32'h0, 32'(rd[g ? `ATD_STAT_JNR : `ATD_STAT_RNR]));
			watch(g, 30);
			chk("pending_cleared", 32'h0, 32'(cnt));
		end
		// Delay of six cycles: a start right after a conversion is dropped
		bus(1'b1, `ATD_OFF_CTRL, 32'h2 << `ATD_CTRL_DELS);
		bus(1'b1, `ATD_OFF_START, 32'h1);
		span(0);
		bus(1'b1, `ATD_OFF_START, 32'h1);
		watch(0, 20);
		chk("start_in_delay", 32'h0, 32'(cnt));
		bus(1'b1, `ATD_OFF_START, 32'h1);
		span(0);
		chk("after_delay", 32'd16, 32'(cnt));
		exp_done += 2;
		// Let the six-cycle delay run out before the freeze setup
		repeat (8) @(posedge hclk);
		// Freeze: a new regular conversion waits for the result read
		bus(1'b1, `ATD_OFF_CTRL, 32'h1 << `ATD_CTRL_DELS);
		bus(1'b1, `ATD_OFF_START, 32'h1);
		span(0);
		exp_done++;
		bus(1'b1, `ATD_OFF_START, 32'h1);
		watch(0, 30);
		chk("frozen", 32'h0, 32'(cnt));
		bus(1'b0, `ATD_OFF_RESULT, 32'h0);
		chk("result", 32'(exp_done), {16'h0, rd[15:0]});
		// The start held during the freeze runs as soon as the read clears the hold
		span(0);
		chk("thawed", 32'd16, 32'(cnt));
		exp_done++;
		bus(1'b0, `ATD_OFF_RESULT, 32'h0);
		chk("result_thawed", 32'(exp_done), {16'h0, rd[15:0]});
		// Auto mode runs the injected group after the regular one
		bus(1'b1, `ATD_OFF_CTRL, 32'h1 << `ATD_CTRL_AUTO);
		bus(1'b1, `ATD_OFF_START, 32'h1);
		span(0);
		watch(1, 10);
		chk("auto_injected", 32'h1, 32'(cnt));
		repeat (30) @(posedge hclk);
		final_report;
	end
endmodule
